// ==== design/sap_pkg.sv ====
// Shared constants, types and helpers for the converter host port.
`default_nettype none
package sap_pkg;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int T_CONV_NS       = 7400;
  localparam int T_BUSY_DLY_NS   = 220;
  localparam int CONV_CYCLES     = T_CONV_NS / CLK_PERIOD_NS;
  localparam int BUSY_DLY_CYCLES = T_BUSY_DLY_NS / CLK_PERIOD_NS;
  localparam int CNT_W           = 9;
  localparam int DATA_W          = 16;
  localparam int BYTE_W          = 8;

  localparam logic [CNT_W-1:0]  CNT_ZERO   = 9'h000;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 9'h001;
  localparam logic [CNT_W-1:0]  CONV_LAST  = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0]  BUSY_LAST  = CNT_W'(BUSY_DLY_CYCLES - 1);
  localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;

  typedef logic [DATA_W-1:0] sap_word_t;

  typedef enum logic [1:0] {
    SAP_IDLE,
    SAP_CONV,
    SAP_SETTLE
  } sap_state_e;

  // Exchanges the upper and lower bytes when the swap select is high.
  function automatic sap_word_t sap_byte_order(input sap_word_t w, input logic swap);
    sap_byte_order = swap ? {w[BYTE_W-1:0], w[DATA_W-1:BYTE_W]} : w;
  endfunction
endpackage
`default_nettype wire

// ==== design/sap_lat_if.sv ====
// Signals between the conversion control and the output latch.
`default_nettype none
interface sap_lat_if;
  import sap_pkg::*;
  logic      load;
  sap_word_t code;
  logic      swap;
  logic      enable;
  sap_word_t data;
  logic      oe_n;
  modport ctrl  (output load, code, swap, enable, input data, oe_n);
  modport latch (input load, code, swap, enable, output data, oe_n);
endinterface
`default_nettype wire

// ==== design/sap_result_latch.sv ====
// Result latch with byte ordering and registered bus drivers.
`default_nettype none
module sap_result_latch (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  sap_lat_if.latch  lat
);
  import sap_pkg::*;

  typedef struct packed {
    sap_word_t code_q;
    sap_word_t data_q;
    logic      oe_n_q;
  } sap_lat_s;

  sap_lat_s st_q;
  sap_lat_s st_d;

  always_comb begin
    st_d = st_q;
    if (lat.load) begin
      st_d.code_q = lat.code;
    end
    st_d.data_q = sap_byte_order(st_q.code_q, lat.swap);
    st_d.oe_n_q = ~lat.enable;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '{code_q: RESULT_RST, data_q: RESULT_RST, oe_n_q: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign lat.data = st_q.data_q;
  assign lat.oe_n = st_q.oe_n_q;

  a_natural_order: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $stable(st_q.code_q) && $past(!lat.swap) |-> lat.data == st_q.code_q)
    else $error("Unswapped output does not match the latched result.");
  a_swapped_order: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $stable(st_q.code_q) && $past(lat.swap) |->
      lat.data == {st_q.code_q[BYTE_W-1:0], st_q.code_q[DATA_W-1:BYTE_W]})
    else $error("Swapped output does not exchange the bytes.");
  a_drivers_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ##1 lat.oe_n == !$past(lat.enable))
    else $error("Bus drivers do not follow the select one cycle later.");
  a_previous_kept: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !lat.load |=> $stable(st_q.code_q))
    else $error("Latched result changed without a load.");
  c_swapped_read: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    lat.swap && !lat.oe_n);
endmodule
`default_nettype wire

// ==== design/sap_adc_port.sv ====
// Conversion control and parallel readout port of the converter.
// Contract
// - With chip select low, falling read/convert enters hold and starts a conversion.
// - Chip select and read/convert are ORed; falling chip select can start too.
// - With chip select low, rising read/convert enables the result drivers.
// - With read/convert high, falling chip select enables the result drivers.
// - Result bits are high impedance when chip select high or read/convert low; here o_result_oe_n goes high and o_result_bits stays driven.
// - Swap select low gives natural order; high exchanges the two bytes.
// - Busy is low during a conversion and high otherwise.
// - The new result is latched before busy rises.
// - A valid result is ready within 8 us of the start edge.
// - Busy rises about 220 ns after the internal end of conversion.
// - Result is valid at least 50 ns before busy rises.
// - Previous result stays latched about 7.4 us into the next conversion.
// - Data is valid 10 to 83 ns after enable or swap change.
// - The result is a two's-complement code passed through unchanged.
// - Start requests during a conversion are ignored; here a start still held low when busy rises begins a new conversion at once.
// - At conversion end the 16-bit result is loaded into the output latch.
`default_nettype none
module sap_adc_port (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_cs_n,
  input  wire logic              i_rc_n,
  input  wire logic              i_half_swap,
  input  wire sap_pkg::sap_word_t i_sar_code,
  output var  sap_pkg::sap_word_t o_result_bits,
  output var  logic              o_result_oe_n,
  output var  logic              o_busy,
  output var  logic              o_hold
);
  import sap_pkg::*;

  typedef struct packed {
    sap_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic             start_n_prev;
    logic             rearm;
    logic             busy;
    logic             hold;
  } sap_ctl_s;

  sap_ctl_s  st_q;
  sap_ctl_s  st_d;
  logic      start_n;
  logic      start_fall;
  logic      load;
  sap_lat_if lat ();

  assign start_n    = i_cs_n | i_rc_n;
  assign start_fall = ~start_n & st_q.start_n_prev;
  assign load       = (st_q.state == SAP_CONV) && (st_q.cnt == CONV_LAST);

  always_comb begin
    st_d              = st_q;
    st_d.start_n_prev = start_n;
    st_d.rearm        = 1'b0;
    case (st_q.state)
      SAP_IDLE: begin
        if (start_fall || (st_q.rearm && !start_n)) begin
          st_d.state = SAP_CONV;
          st_d.cnt   = CNT_ZERO;
          st_d.busy  = 1'b0;
          st_d.hold  = 1'b1;
        end
      end
      SAP_CONV: begin
        st_d.cnt = st_q.cnt + CNT_ONE;
        if (st_q.cnt == CONV_LAST) begin
          st_d.state = SAP_SETTLE;
          st_d.cnt   = CNT_ZERO;
          st_d.hold  = 1'b0;
        end
      end
      SAP_SETTLE: begin
        st_d.cnt = st_q.cnt + CNT_ONE;
        if (st_q.cnt == BUSY_LAST) begin
          st_d.state = SAP_IDLE;
          st_d.busy  = 1'b1;
          st_d.rearm = 1'b1;
        end
      end
      default: begin
        st_d.state = SAP_IDLE;
        st_d.busy  = 1'b1;
        st_d.hold  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '{state: SAP_IDLE, cnt: CNT_ZERO, start_n_prev: 1'b1, rearm: 1'b0,
                busy: 1'b1, hold: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign lat.load   = load;
  assign lat.code   = i_sar_code;
  assign lat.swap   = i_half_swap;
  assign lat.enable = ~i_cs_n & i_rc_n;

  sap_result_latch u_latch (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .lat        (lat)
  );

  assign o_result_bits = lat.data;
  assign o_result_oe_n = lat.oe_n;
  assign o_busy        = st_q.busy;
  assign o_hold        = st_q.hold;

  localparam int LOW_TOTAL = CONV_CYCLES + BUSY_DLY_CYCLES;
  logic [9:0] low_cnt_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_q <= 10'h000;
    end else begin
      low_cnt_q <= o_busy ? 10'h000 : low_cnt_q + 10'h001;
    end
  end

  a_start_enters_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    st_q.state == SAP_IDLE && start_fall |=> !o_busy && o_hold)
    else $error("Start edge did not begin a conversion.");
  a_busy_stays_low: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $fell(o_busy) |-> !o_busy [*8])
    else $error("Busy rose early in a conversion.");
  a_conv_length: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_busy) |-> low_cnt_q == LOW_TOTAL)
    else $error("Busy low time differs from the conversion length.");
  a_load_before_busy: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    load |-> ##12 $rose(o_busy))
    else $error("Busy did not rise twelve cycles after the latch load.");
  a_restart_ignored: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    st_q.state == SAP_CONV && start_fall && st_q.cnt != CONV_LAST |=>
      st_q.state == SAP_CONV && st_q.cnt == $past(st_q.cnt) + CNT_ONE)
    else $error("A start request disturbed a running conversion.");
  a_immediate_restart: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_busy) && !start_n |=> !o_busy)
    else $error("Held start did not restart the converter.");

  c_conversion_done: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_busy));
  c_cs_started: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_rc_n && $fell(i_cs_n) && st_q.state == SAP_IDLE);
  c_restart: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_busy) && !start_n);
endmodule
`default_nettype wire

// ==== testbench/sap_host.sv ====
// Host bus model driving chip select and read/convert.
`default_nettype none
module sap_host (
  input  wire logic i_core_clk,
  output var  logic o_cs_n,
  output var  logic o_rc_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n = 1'b1;
    o_rc_n = 1'b1;
  end
  task automatic set_lines(input logic cs, input logic rc);
    o_cs_n <= cs;
    o_rc_n <= rc;
  endtask
  // Raises a start by either line last; returns at the edge that lowers both.
  task automatic start(input logic cs_first);
    @(posedge i_core_clk);
    set_lines(!cs_first, cs_first);
    @(posedge i_core_clk);
    set_lines(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the converter host port.
`default_nettype none
module tb;
  import sap_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam sap_word_t CORNER [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
  logic      clk = 1'b0;
  logic      reset_n = 1'b0;
  logic      swap = 1'b0;
  sap_word_t sar = 16'h0000;
  logic      cs_n;
  logic      rc_n;
  logic      busy;
  logic      oe_n;
  logic      hold;
  sap_word_t res;
  sap_word_t last;
  int        n_fail = 0;
  int        n_tests = 0;
  always #10 clk = ~clk;
  sap_host host_u (.i_core_clk(clk), .o_cs_n(cs_n), .o_rc_n(rc_n));
  sap_adc_port dut_u (.i_core_clk(clk), .i_reset_n(reset_n), .i_cs_n(cs_n),
    .i_rc_n(rc_n), .i_half_swap(swap), .i_sar_code(sar), .o_result_bits(res),
    .o_result_oe_n(oe_n), .o_busy(busy), .o_hold(hold));
  function automatic sap_word_t ord(input sap_word_t w, input logic s);
    return s ? {w[7:0], w[15:8]} : w;
  endfunction
  task automatic chk(input string nm, input sap_word_t exp, input sap_word_t got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input int i);
    int        n;
    sap_word_t code;
    logic      s;
    code = (i < 4) ? CORNER[i] : sap_word_t'($urandom);
    s = 1'($urandom);
    @(posedge clk);
    sar <= code;
    swap <= s;
    host_u.start(i[0]);
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("busy_fall", 2, 16'(n));
    chk("hold", 1, 16'(hold));
    n = 0;
    while (busy === 1'b0 && n < 450) begin
      @(negedge clk);
      n++;
      if (n == (i[1] ? 20 : 2))
        host_u.set_lines(1'b0, 1'b1);
      if (n == 100)
        host_u.set_lines(1'b0, 1'b0);
      if (n == 102) begin
        chk("oe_rc_low", 1, 16'(oe_n));
        host_u.set_lines(1'b0, 1'b1);
      end
      if (n == 360) begin
        chk("prev", ord(last, s), res);
        chk("hold_conv", 1, 16'(hold));
      end
      if (n == 375) begin
        chk("new", ord(code, s), res);
        chk("hold_done", 0, 16'(hold));
      end
    end
    chk("busy_len", 381, 16'(n));
    chk("oe_read", 0, 16'(oe_n));
    @(posedge clk);
    swap <= !s;
    @(posedge clk);
    @(negedge clk);
    chk("swap", ord(code, !s), res);
    host_u.set_lines(1'b1, 1'b1);
    repeat (2) @(negedge clk);
    chk("oe_cs_high", 1, 16'(oe_n));
    host_u.set_lines(1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk("oe_cs_fall", 0, 16'(oe_n));
    host_u.set_lines(1'b1, 1'b1);
    repeat (120) @(negedge clk);
    last = code;
  endtask
  // Keeps the start condition low as busy rises, so a second conversion follows at once.
  task automatic held_start();
    int n;
    host_u.start(1'b0);
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("held_fall", 2, 16'(n));
    n = 0;
    while (busy === 1'b0 && n < 450) begin
      @(negedge clk);
      n++;
    end
    chk("held_len", 381, 16'(n));
    @(negedge clk);
    chk("held_restart", 0, 16'(busy));
    host_u.set_lines(1'b1, 1'b1);
    n = 0;
    while (busy === 1'b0 && n < 450) begin
      @(negedge clk);
      n++;
    end
    chk("held_len2", 381, 16'(n));
    repeat (120) @(negedge clk);
  endtask
  initial begin
    void'($urandom(65));
    last = 16'h0000;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("rst_busy", 1, 16'(busy));
    chk("rst_oe", 1, 16'(oe_n));
    for (int i = 0; i < 8; i++) begin
      run(i);
      $display("test %0d done", i);
    end
    held_start();
    $display("test 8 done");
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
